// ==== hw/tcru_edge_sampler.sv ====
// Two-flop synchroniser plus machine-cycle sampled falling edge detector
`timescale 1ns/1ns
`default_nettype none
module tcru_edge_sampler (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic sample,
  output logic level,
  output logic fall
);
  logic sync1;
  logic sync2;
  always_ff @(posedge clk) begin
    sync1 <= pin;
    sync2 <= sync1;
  end
  // Only sample point updates stored level; a level must last a machine cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b1;
      fall <= 1'b0;
    end else begin
      fall <= 1'b0;
      if (sample) begin
        level <= sync2;
        fall <= level & ~sync2;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/tcru_pkg.sv ====
// Package: register offsets, field positions, reset values and timing of the timer unit
package tcru_pkg;
  // ==================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h10;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h14;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  // ==================================================
  // Control register fields
  localparam int CTL_OVF = 7;
  localparam int CTL_EXF = 6;
  localparam int CTL_RCLK = 5;
  localparam int CTL_TRANSMIT_CLOCK_SOURCE_SELECT = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CT = 1;
  localparam int CTL_CPRL = 0;
  // Mode register field
  localparam int MOD_DOWN_COUNT_ENABLE = 0;
  // Interrupt enable fields
  localparam int IE_GLOBAL = 7;
  localparam int IE_TIMER = 5;
  // Status register fields
  localparam int ST_IRQ = 0;
  localparam int ST_IDLE_WAKE = 1;
  localparam int ST_FROZEN = 2;
  // ==================================================
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // ==================================================
  // Machine cycle timing
  localparam int OSC_PER_MACHINE = 12;
  localparam int MC_WIDTH = 4;
  localparam logic [3:0] MC_LAST = 4'hb;
  localparam logic [3:0] PHASE_SAMPLE = 4'h9;
  localparam logic [3:0] PHASE_OVF_SET = 4'h3;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  typedef enum logic [1:0] {
    TCRU_OFF = 2'b00,
    TCRU_RELOAD = 2'b01,
    TCRU_CAPTURE = 2'b10,
    TCRU_BAUD = 2'b11
  } tcru_mode_t;
endpackage

// ==== hw/tcru_top.sv ====
// Sixteen-bit timer with capture, auto-reload and baud modes behind an APB slave
// How it works
// - Timer function adds one to the count every machine cycle of twelve clocks.
// - Mode comes from run, serial clock selects and capture/reload select.
// - Count pin sampled once per machine cycle; high then low counts one event.
// - Incremented count appears in the machine cycle after detection.
// - Edge recognition spans two machine cycles, max rate one per 24 clocks.
// - Capture mode without edge enable is plain 16-bit counter setting overflow.
// - Capture mode with edge enable copies count into capture registers on trigger.
// - That trigger edge also sets the external edge flag.
// - Down-count enable resets to zero; zero means count up.
// - Reload mode with down-count enable follows trigger pin level for direction.
// - Interrupt request is overflow flag OR external edge flag.
// - Flags are only cleared by software writing zero.
// - Overflow flag set early in the overflow cycle and seen at once.
// - Request reaches processor only with timer enable and global enable.
// - Timer runs in idle; enabled interrupt ends idle.
// - Power-down halts the timer and keeps its registers.
// - Reset returns all timer registers to reset values.
// - No overflow flag while either serial clock select is set.
// - Edge flag gives no interrupt in up/down mode.
// - Reload mode reloads on up-count overflow, and on trigger edge when edge enable is set and down-count enable is clear.
// - Counter select set counts count-pin falling edges.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tcru_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // External pins
  input wire logic COUNT_INPUT_PIN,
  input wire logic TRIGGER_DIRECTION_PIN,
  // Power state
  input wire logic IDLE_MODE,
  input wire logic POWER_DOWN,
  // Interrupt towards processor
  output logic TIMER_IRQ,
  output logic IDLE_WAKE
);
  // ==================================================
  // Registers
  logic [7:0] timer_two_control_register;
  logic [7:0] timer_two_mode_register;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] capture_reload_low;
  logic [7:0] capture_reload_high;
  logic [7:0] interrupt_enable_register;
  logic [3:0] phase;
  logic tick_sample;
  logic tick_ovf;
  logic count_level;
  logic count_fall;
  logic trig_level;
  logic trig_fall;
  logic count_pending;
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] next_count;
  logic count_step;
  logic count_down;
  logic overflow;
  logic edge_reload;
  logic edge_capture;
  logic set_ovf;
  logic set_exf;
  logic wr_en;
  logic wr_control;
  logic wr_mode;
  logic wr_count_low;
  logic wr_count_high;
  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_int_enable;
  logic req_raw;
  logic exf_for_irq;
  tcru_pkg::tcru_mode_t mode;

  assign count = {count_high_byte, count_low_byte};
  assign reload = {capture_reload_high, capture_reload_low};
  assign wr_en = PSEL & PENABLE & PWRITE & ~POWER_DOWN;

  // ==================================================
  // Register write strobes, one per writable word (status has none)
  assign wr_control = wr_en & (PADDR == tcru_pkg::ADDR_CONTROL);
  assign wr_mode = wr_en & (PADDR == tcru_pkg::ADDR_MODE);
  assign wr_count_low = wr_en & (PADDR == tcru_pkg::ADDR_COUNT_LOW);
  assign wr_count_high = wr_en & (PADDR == tcru_pkg::ADDR_COUNT_HIGH);
  assign wr_reload_low = wr_en & (PADDR == tcru_pkg::ADDR_RELOAD_LOW);
  assign wr_reload_high = wr_en & (PADDR == tcru_pkg::ADDR_RELOAD_HIGH);
  assign wr_int_enable = wr_en & (PADDR == tcru_pkg::ADDR_INT_ENABLE);

  // ==================================================
  // Mode decode
  function automatic tcru_pkg::tcru_mode_t decode_mode(input logic [7:0] ctl);
    tcru_pkg::tcru_mode_t m;
    m = tcru_pkg::TCRU_OFF;
    if (ctl[tcru_pkg::CTL_RUN]) begin
      if (ctl[tcru_pkg::CTL_RCLK] | ctl[tcru_pkg::CTL_TRANSMIT_CLOCK_SOURCE_SELECT]) begin
        m = tcru_pkg::TCRU_BAUD;
      end else if (ctl[tcru_pkg::CTL_CPRL]) begin
        m = tcru_pkg::TCRU_CAPTURE;
      end else begin
        m = tcru_pkg::TCRU_RELOAD;
      end
    end
    return m;
  endfunction
  assign mode = decode_mode(timer_two_control_register);

  // ==================================================
  // Machine cycle phase counter
  // freeze on power-down
  always_ff @(posedge CLK) begin
    if (RST) begin
      phase <= '0;
    end else if (!POWER_DOWN) begin
      phase <= (phase == tcru_pkg::MC_LAST) ? 4'h0 : phase + 4'h1;
    end
  end
  assign tick_sample = ~POWER_DOWN & (phase == tcru_pkg::PHASE_SAMPLE);
  assign tick_ovf = ~POWER_DOWN & (phase == tcru_pkg::PHASE_OVF_SET);

  // ==================================================
  // Pin samplers
  // sample once per machine cycle
  tcru_edge_sampler u_count_pin (
    .clk(CLK),
    .rst(RST),
    .pin(COUNT_INPUT_PIN),
    .sample(tick_sample),
    .level(count_level),
    .fall(count_fall)
  );
  tcru_edge_sampler u_trig_pin (
    .clk(CLK),
    .rst(RST),
    .pin(TRIGGER_DIRECTION_PIN),
    .sample(tick_sample),
    .level(trig_level),
    .fall(trig_fall)
  );

  // event applied at next machine cycle step
  // detection plus apply gives two machine cycles per edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      count_pending <= 1'b0;
    end else if (count_fall) begin
      count_pending <= 1'b1;
    end else if (tick_ovf) begin
      count_pending <= 1'b0;
    end
  end

  // ==================================================
  // Count step and direction
  always_comb begin
    count_step = 1'b0;
    if (mode != tcru_pkg::TCRU_OFF && tick_ovf) begin
      if (timer_two_control_register[tcru_pkg::CTL_CT]) begin
        count_step = count_pending;
      end else begin
        count_step = 1'b1;
      end
    end
  end

  assign count_down = (mode == tcru_pkg::TCRU_RELOAD) &
    timer_two_mode_register[tcru_pkg::MOD_DOWN_COUNT_ENABLE] & ~trig_level;

  assign overflow = count_step & (count_down ? (count == reload) : (count == tcru_pkg::ALL_ONES));

  // trigger reload when edge enabled and down-count enable clear
  // Edge left over from the last sample must not move state once frozen
  assign edge_reload = trig_fall & ~POWER_DOWN & (mode == tcru_pkg::TCRU_RELOAD) &
    timer_two_control_register[tcru_pkg::CTL_EXEN] &
    ~timer_two_mode_register[tcru_pkg::MOD_DOWN_COUNT_ENABLE];
  assign edge_capture = trig_fall & ~POWER_DOWN & (mode == tcru_pkg::TCRU_CAPTURE) &
    timer_two_control_register[tcru_pkg::CTL_EXEN];

  always_comb begin
    next_count = count;
    if (count_step) begin
      next_count = count_down ? count - 16'h0001 : count + 16'h0001;
    end
    if (overflow) begin
      if (count_down) begin
        next_count = tcru_pkg::ALL_ONES;
      end else if (mode != tcru_pkg::TCRU_CAPTURE) begin
        next_count = reload;
      end else begin
        next_count = 16'h0000;
      end
    end
    if (edge_reload) begin
      next_count = reload;
    end
  end

  // ==================================================
  // Count registers
  // reset values
  always_ff @(posedge CLK) begin
    if (RST) begin
      count_low_byte <= tcru_pkg::BYTE_RESET;
      count_high_byte <= tcru_pkg::BYTE_RESET;
    end else if (wr_count_low) begin
      count_low_byte <= PWDATA[7:0];
    end else if (wr_count_high) begin
      count_high_byte <= PWDATA[7:0];
    end else begin
      // runs in idle; halted by frozen ticks
      count_low_byte <= next_count[7:0];
      count_high_byte <= next_count[15:8];
    end
  end

  // ==================================================
  // Capture/reload registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      capture_reload_low <= tcru_pkg::BYTE_RESET;
      capture_reload_high <= tcru_pkg::BYTE_RESET;
    end else if (edge_capture) begin
      // capture wins over a write in the same cycle
      capture_reload_low <= count_low_byte;
      capture_reload_high <= count_high_byte;
    end else if (wr_reload_low) begin
      capture_reload_low <= PWDATA[7:0];
    end else if (wr_reload_high) begin
      capture_reload_high <= PWDATA[7:0];
    end
  end

  // ==================================================
  // Control register and flags
  // no overflow flag in baud mode
  // set in the overflow machine cycle itself
  assign set_ovf = overflow & (mode != tcru_pkg::TCRU_BAUD);
  // edge flag on capture or reload edge
  assign set_exf = edge_capture | edge_reload;

  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_two_control_register <= tcru_pkg::CONTROL_RESET;
    end else begin
      if (wr_control) begin
        timer_two_control_register <= PWDATA[7:0];
      end
      // only software clears; set beats clear
      if (set_ovf) begin
        timer_two_control_register[tcru_pkg::CTL_OVF] <= 1'b1;
      end
      if (set_exf) begin
        timer_two_control_register[tcru_pkg::CTL_EXF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_two_mode_register <= tcru_pkg::MODE_RESET;
    end else if (wr_mode) begin
      timer_two_mode_register <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      interrupt_enable_register <= tcru_pkg::BYTE_RESET;
    end else if (wr_int_enable) begin
      interrupt_enable_register <= PWDATA[7:0];
    end
  end

  // ==================================================
  // Interrupt request
  // edge flag masked in up/down mode
  assign exf_for_irq = timer_two_control_register[tcru_pkg::CTL_EXF] &
    ~timer_two_mode_register[tcru_pkg::MOD_DOWN_COUNT_ENABLE];
  assign req_raw = timer_two_control_register[tcru_pkg::CTL_OVF] | exf_for_irq;

  always_ff @(posedge CLK) begin
    if (RST) begin
      TIMER_IRQ <= 1'b0;
      IDLE_WAKE <= 1'b0;
    end else begin
      TIMER_IRQ <= req_raw & interrupt_enable_register[tcru_pkg::IE_TIMER] &
        interrupt_enable_register[tcru_pkg::IE_GLOBAL];
      IDLE_WAKE <= IDLE_MODE & req_raw & interrupt_enable_register[tcru_pkg::IE_TIMER] &
        interrupt_enable_register[tcru_pkg::IE_GLOBAL];
    end
  end

  // ==================================================
  // APB read side
  // Zero wait states keep the bus simple; no error response
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        tcru_pkg::ADDR_CONTROL: PRDATA <= {24'h000000, timer_two_control_register};
        tcru_pkg::ADDR_MODE: PRDATA <= {24'h000000, timer_two_mode_register};
        tcru_pkg::ADDR_COUNT_LOW: PRDATA <= {24'h000000, count_low_byte};
        tcru_pkg::ADDR_COUNT_HIGH: PRDATA <= {24'h000000, count_high_byte};
        tcru_pkg::ADDR_RELOAD_LOW: PRDATA <= {24'h000000, capture_reload_low};
        tcru_pkg::ADDR_RELOAD_HIGH: PRDATA <= {24'h000000, capture_reload_high};
        tcru_pkg::ADDR_INT_ENABLE: PRDATA <= {24'h000000, interrupt_enable_register};
        tcru_pkg::ADDR_STATUS: PRDATA <= {29'h0, POWER_DOWN, IDLE_WAKE, TIMER_IRQ};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench: APB-driven scenarios for the timer unit
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cnt_pin, trig_pin, idle, pd, irq, wake;
  logic [31:0] exp_q[$];
  logic [15:0] v, w;
  int failures = 0;
  int check_count = 0;
  tcru_top DUT (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .COUNT_INPUT_PIN(cnt_pin),
    .TRIGGER_DIRECTION_PIN(trig_pin), .IDLE_MODE(idle), .POWER_DOWN(pd),
    .TIMER_IRQ(irq), .IDLE_WAKE(wake));
  tcru_pin_source src (.clk(clk), .count_pin(cnt_pin), .trig_pin(trig_pin));
  always #4 clk = ~clk;
  // ==================================================
  // Checking
  task automatic compare_rd(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: read %h expected %h", $time, g, e);
    end
  endtask
  task automatic compare_bit(input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: output %b expected %b", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) begin
      compare_rd(exp_q.pop_front(), prdata);
    end
  end
  // ==================================================
  // Bus master; the idle edge at the end holds psel low for one cycle between transfers
  task automatic xfer(input bit wrt, input logic [7:0] a, input logic [7:0] d);
    if (!wrt) exp_q.push_back({24'h0, d});
    psel <= 1'h1;
    pwrite <= wrt;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial begin
    {clk, psel, penable, pwrite, idle, pd} = 6'h0;
    rst = 1'h1;
    paddr = 8'h0;
    pwdata = 32'h0;
    void'($urandom(32'hb6fd));
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    xfer(1'h0, tcru_pkg::ADDR_CONTROL, tcru_pkg::CONTROL_RESET);
    xfer(1'h0, tcru_pkg::ADDR_MODE, tcru_pkg::MODE_RESET);
    xfer(1'h0, 8'h20, 8'h00);
    // Window of 60 edges holds exactly five ticks whatever the phase
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h04);
    repeat (57) @(posedge clk);
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h00);
    xfer(1'h0, tcru_pkg::ADDR_COUNT_LOW, 8'h05);
    v = 16'($urandom_range(16'hfffd, 0));
    w = v + 16'h1;
    xfer(1'h1, tcru_pkg::ADDR_RELOAD_LOW, v[7:0]);
    xfer(1'h1, tcru_pkg::ADDR_RELOAD_HIGH, v[15:8]);
    for (int m = 0; m < 2; m++) begin
      xfer(1'h1, tcru_pkg::ADDR_COUNT_LOW, 8'hff);
      xfer(1'h1, tcru_pkg::ADDR_COUNT_HIGH, 8'hff);
      xfer(1'h1, tcru_pkg::ADDR_CONTROL, m ? 8'h14 : 8'h04);
      repeat (18) @(posedge clk);
      xfer(1'h0, tcru_pkg::ADDR_CONTROL, m ? 8'h14 : 8'h84);
      xfer(1'h1, tcru_pkg::ADDR_CONTROL, m ? 8'h10 : 8'h80);
      xfer(1'h0, tcru_pkg::ADDR_CONTROL, m ? 8'h10 : 8'h80);
      xfer(1'h0, tcru_pkg::ADDR_COUNT_LOW, w[7:0]);
      xfer(1'h0, tcru_pkg::ADDR_COUNT_HIGH, w[15:8]);
    end
    v = 16'($urandom);
    w = v + 16'h3;
    xfer(1'h1, tcru_pkg::ADDR_COUNT_LOW, v[7:0]);
    xfer(1'h1, tcru_pkg::ADDR_COUNT_HIGH, v[15:8]);
    xfer(1'h1, tcru_pkg::ADDR_INT_ENABLE, 8'ha0);
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h0f);
    src.fall_pulses(1, 1'h1);
    repeat (4) @(posedge clk);
    compare_bit(1'h1, irq);
    xfer(1'h0, tcru_pkg::ADDR_RELOAD_LOW, v[7:0]);
    xfer(1'h0, tcru_pkg::ADDR_RELOAD_HIGH, v[15:8]);
    src.fall_pulses(3, 1'h0);
    repeat (30) @(posedge clk);
    xfer(1'h0, tcru_pkg::ADDR_COUNT_LOW, w[7:0]);
    xfer(1'h0, tcru_pkg::ADDR_COUNT_HIGH, w[15:8]);
    idle <= 1'h1;
    repeat (3) @(posedge clk);
    compare_bit(1'h1, wake);
    // Writes and pin events while frozen must leave no trace
    pd <= 1'h1;
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h00);
    src.fall_pulses(1, 1'h0);
    xfer(1'h0, tcru_pkg::ADDR_CONTROL, {v > 16'hfffc, 7'h4f});
    xfer(1'h0, tcru_pkg::ADDR_COUNT_LOW, w[7:0]);
    xfer(1'h0, tcru_pkg::ADDR_STATUS, 8'h07);
    pd <= 1'h0;
    idle <= 1'h0;
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h0f);
    repeat (2) @(posedge clk);
    compare_bit(1'h0, irq);
    // Trigger edge reloads while no count pulses arrive
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h0e);
    src.fall_pulses(1, 1'h1);
    xfer(1'h0, tcru_pkg::ADDR_CONTROL, 8'h4e);
    xfer(1'h0, tcru_pkg::ADDR_COUNT_LOW, v[7:0]);
    xfer(1'h0, tcru_pkg::ADDR_COUNT_HIGH, v[15:8]);
    // Trigger held low counts down over exactly three ticks
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h00);
    src.set_level(1'h1, 1'h0);
    v = 16'($urandom_range(16'hfffe, 0));
    w = v + 16'h1;
    xfer(1'h1, tcru_pkg::ADDR_RELOAD_LOW, v[7:0]);
    xfer(1'h1, tcru_pkg::ADDR_RELOAD_HIGH, v[15:8]);
    xfer(1'h1, tcru_pkg::ADDR_COUNT_LOW, w[7:0]);
    xfer(1'h1, tcru_pkg::ADDR_COUNT_HIGH, w[15:8]);
    xfer(1'h1, tcru_pkg::ADDR_MODE, 8'h01);
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h04);
    repeat (30) @(posedge clk);
    xfer(1'h0, tcru_pkg::ADDR_CONTROL, 8'h84);
    xfer(1'h1, tcru_pkg::ADDR_CONTROL, 8'h40);
    xfer(1'h0, tcru_pkg::ADDR_COUNT_LOW, 8'hfe);
    xfer(1'h0, tcru_pkg::ADDR_COUNT_HIGH, 8'hff);
    compare_bit(1'h0, irq);
    src.set_level(1'h1, 1'h1);
    xfer(1'h1, tcru_pkg::ADDR_INT_ENABLE, 8'h00);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    xfer(1'h0, tcru_pkg::ADDR_CONTROL, tcru_pkg::CONTROL_RESET);
    xfer(1'h0, tcru_pkg::ADDR_RELOAD_LOW, tcru_pkg::BYTE_RESET);
    end_sim();
  end
endmodule
`default_nettype wire

// ==== testbench/tcru_assertions.sv ====
// Checker: port-level properties of the timer unit
`timescale 1ns/1ns
`default_nettype none
module tcru_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Power and interrupt
  input wire logic IDLE_MODE,
  input wire logic POWER_DOWN,
  input wire logic TIMER_IRQ,
  input wire logic IDLE_WAKE
);
  logic wr;
  logic ie_ok;
  assign wr = PSEL && PENABLE && PWRITE && !POWER_DOWN;
  // ==================================================
  // Shadow of both enables, since they are not visible at the ports
  always_ff @(posedge CLK) begin
    if (RST) begin
      ie_ok <= 1'h0;
    end else if (wr && PADDR == tcru_pkg::ADDR_INT_ENABLE) begin
      ie_ok <= PWDATA[tcru_pkg::IE_GLOBAL] && PWDATA[tcru_pkg::IE_TIMER];
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // ==================================================
  // Properties
  a_ready_const: assert property (PREADY && !PSLVERR)
    else $error("slave not ready or erred");
  a_unmapped_zero: assert property (PSEL && PENABLE && !PWRITE && PADDR > 8'h1c
      |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_reset_clears: assert property ($past(RST) |-> !TIMER_IRQ && !IDLE_WAKE)
    else $error("outputs not cleared by reset");
  a_irq_enabled: assert property (TIMER_IRQ |-> $past(ie_ok))
    else $error("request without both enables");
  a_irq_disable: assert property ($fell(ie_ok) |-> ##1 !TIMER_IRQ)
    else $error("request outlived its enable");
  a_wake_exact: assert property (IDLE_WAKE == (TIMER_IRQ && $past(IDLE_MODE)))
    else $error("wake not request gated by idle");
  a_irq_sticky: assert property (!$past(RST) && $fell(TIMER_IRQ) |-> $past(wr, 2))
    else $error("request dropped without write");
  a_frozen_irq: assert property (!$past(RST) && $past(POWER_DOWN, 2) |-> $stable(TIMER_IRQ))
    else $error("request moved in power down");
  c_irq: cover property ($rose(TIMER_IRQ));
  c_wake: cover property ($rose(IDLE_WAKE));
  c_frozen: cover property (POWER_DOWN && TIMER_IRQ);
endmodule
bind tcru_top tcru_assertions u_chk (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IDLE_MODE(IDLE_MODE), .POWER_DOWN(POWER_DOWN),
  .TIMER_IRQ(TIMER_IRQ), .IDLE_WAKE(IDLE_WAKE)
);
`default_nettype wire

// ==== testbench/tcru_pin_source.sv ====
// Partner model: external sources of the count and trigger pins
`timescale 1ns/1ns
`default_nettype none
module tcru_pin_source (
  // Clock
  input wire logic clk,
  // Pins, idle high as with a pull-up
  output logic count_pin,
  output logic trig_pin
);
  initial begin
    count_pin = 1'h1;
    trig_pin = 1'h1;
  end
  // ==================================================
  // Pulses
  // each level held over a machine cycle
  task automatic fall_pulses(input int n, input bit trig);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge clk);
      if (trig) trig_pin <= 1'h0;
      else count_pin <= 1'h0;
      repeat (16) @(posedge clk);
      if (trig) trig_pin <= 1'h1;
      else count_pin <= 1'h1;
    end
  endtask
  // Steady level, used for count direction
  task automatic set_level(input bit trig, input bit lvl);
    @(posedge clk);
    if (trig) trig_pin <= lvl;
    else count_pin <= lvl;
  endtask
endmodule
`default_nettype wire
